// ---- common/ipf_pkg.sv ----
package ipf_pkg;

  // Number of priority fields held by this block
  localparam int NSRC = 6;

  // Register word offsets on the bus (byte addresses)
  localparam logic [11:0] OFS_GROUP_B = 12'h000;
  localparam logic [11:0] OFS_GROUP_C = 12'h004;

  // Field encodings
  localparam logic [2:0] FIELD_RESET = 3'h4;
  localparam logic [2:0] PRIO_MAX = 3'h7;
  localparam logic [2:0] PRIO_MIN = 3'h1;
  localparam logic [2:0] PRIO_OFF = 3'h0;
  localparam int FIELD_W = 3;

  // Source order inside the output array
  typedef enum logic [2:0] {
    SRC_I2C_SLAVE2 = 3'b000,
    SRC_TIMER7     = 3'b001,
    SRC_CAN2_RX    = 3'b010,
    SRC_EXT4       = 3'b011,
    SRC_EXT3       = 3'b100,
    SRC_TIMER9     = 3'b101
  } ipf_src_e;

  // Which register holds each source (0 = group_b, 1 = group_c)
  localparam logic SRC_REG [NSRC] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  // Lowest bit of each source's field within its register
  localparam int SRC_LSB [NSRC] = '{4, 0, 12, 8, 4, 0};

  // Per-source priority as seen by the arbiter
  typedef struct packed {
    logic [2:0] level;
    logic enabled;
  } ipf_src_s;

endpackage

// ---- rtl/ipf_top.sv ----
// Functional notes
// RULE1: Field code 111 gives the source the highest level, seven.
// RULE2: Code 001 is level one; code 000 disables the source completely.
// RULE3: Codes map linearly to levels; larger code always means higher priority.
// RULE4: Every field resets to 100, level four; all field bits read and write.
// RULE5: Bits 15, 11, 7 and 3 read zero and ignore writes.
// RULE6: I2C slave two event priority sits in bits 6..4 of group_b.
// RULE7: CAN two receive-ready priority sits in bits 14..12 of group_c.
// RULE8: External interrupt four priority sits in bits 10..8 of group_c.
// RULE9: External interrupt three priority sits in bits 6..4 of group_c.
// RULE10: Timer nine priority sits in bits 2..0 of group_c.
// RULE11: Timer seven priority sits in bits 2..0 of group_b, same encoding.
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module ipf_top
  import ipf_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Priorities toward the arbiter
  output ipf_src_s [NSRC-1:0] src_o
);

  logic [2:0] level_q [NSRC];
  logic [NSRC-1:0] en_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic hit_b;
  logic hit_c;
  logic setup;
  logic commit;
  logic wr_b;
  logic wr_c;
  logic [31:0] rd_word;

  // Address decode
  always_comb
  begin
    hit_b = 1'b0;
    hit_c = 1'b0;
    if (paddr_i == OFS_GROUP_B)
    begin
      hit_b = 1'b1;
    end
    else if (paddr_i == OFS_GROUP_C)
    begin
      hit_c = 1'b1;
    end
  end

  // Phase qualifiers; writes land only on the completing edge
  assign setup = psel_i && !penable_i;
  assign commit = psel_i && penable_i && pready_q;
  assign wr_b = commit && pwrite_i && hit_b;
  assign wr_c = commit && pwrite_i && hit_c;

  // Priority fields, one flop group per source
  for (genvar g = 0; g < NSRC; g++)
  begin : g_src
    localparam int LSB = SRC_LSB[g];
    logic sel;
    assign sel = SRC_REG[g] ? wr_c : wr_b; // RULE6 RULE7 RULE8 RULE9 RULE10 RULE11

    // Enable kept in its own flop so the output is registered
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
      if (!reset_n_i)
      begin
        level_q[g] <= FIELD_RESET; // RULE4
        en_q[g] <= 1'b1;
      end
      else if (sel)
      begin
        level_q[g] <= pwdata_i[LSB +: FIELD_W]; // RULE1 RULE3
        en_q[g] <= (pwdata_i[LSB +: FIELD_W] != PRIO_OFF); // RULE2
      end
    end

    assign src_o[g] = '{level: level_q[g], enabled: en_q[g]};
  end

  // Read word; unimplemented bits stay zero
  always_comb
  begin
    rd_word = 32'h0000_0000; // RULE5
    for (int i = 0; i < NSRC; i++)
    begin
      if ((SRC_REG[i] && hit_c) || (!SRC_REG[i] && hit_b))
      begin
        rd_word[SRC_LSB[i] +: FIELD_W] = level_q[i];
      end
    end
  end

  // Zero-wait answer: data and ready raised for the access phase
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else if (setup)
    begin
      pready_q <= 1'b1;
      pslverr_q <= !(hit_b || hit_c);
      prdata_q <= pwrite_i ? 32'h0000_0000 : rd_word;
    end
    else
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;

  // Checks on the priority fields
  property p_max_code;
    @(posedge clk_i) disable iff (!reset_n_i)
    (wr_c && pwdata_i[2:0] == PRIO_MAX) |=> (level_q[SRC_TIMER9] == 3'h7) && en_q[SRC_TIMER9];
  endproperty
  a_max_code: assert property (p_max_code) else $error("all-ones code did not give level seven"); // RULE1

  property p_off_code;
    @(posedge clk_i) disable iff (!reset_n_i)
    (wr_b && pwdata_i[2:0] == PRIO_OFF) |=> !en_q[SRC_TIMER7] && level_q[SRC_TIMER7] == 3'h0;
  endproperty
  a_off_code: assert property (p_off_code) else $error("zero code left source enabled"); // RULE2

  property p_min_code;
    @(posedge clk_i) disable iff (!reset_n_i)
    (wr_c && pwdata_i[6:4] == PRIO_MIN) |=> en_q[SRC_EXT3] && level_q[SRC_EXT3] == 3'h1;
  endproperty
  a_min_code: assert property (p_min_code) else $error("code 001 did not give level one"); // RULE2

  property p_linear;
    @(posedge clk_i) disable iff (!reset_n_i)
    (level_q[SRC_EXT4] > level_q[SRC_CAN2_RX]) |-> en_q[SRC_EXT4]
      && (en_q[SRC_CAN2_RX] == (level_q[SRC_CAN2_RX] != 3'h0));
  endproperty
  a_linear: assert property (p_linear) else $error("level order or enable disagrees with code"); // RULE3

  property p_reset_value;
    @(posedge clk_i) disable iff (!reset_n_i)
    $rose(reset_n_i) |-> level_q[SRC_I2C_SLAVE2] == 3'h4 && level_q[SRC_TIMER9] == 3'h4 && (&en_q);
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("field not at level four after reset"); // RULE4

  property p_reserved_zero;
    @(posedge clk_i) disable iff (!reset_n_i)
    pready_q |-> prdata_q[31:16] == 16'h0000 && !prdata_q[15] && !prdata_q[11] && !prdata_q[7] && !prdata_q[3];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("unimplemented bit read as one"); // RULE5

  property p_i2c_field;
    @(posedge clk_i) disable iff (!reset_n_i)
    wr_b |=> level_q[SRC_I2C_SLAVE2] == $past(pwdata_i[6:4]);
  endproperty
  a_i2c_field: assert property (p_i2c_field) else $error("i2c slave field not from bits 6..4"); // RULE6

  property p_can_field;
    @(posedge clk_i) disable iff (!reset_n_i)
    wr_c |=> level_q[SRC_CAN2_RX] == $past(pwdata_i[14:12]);
  endproperty
  a_can_field: assert property (p_can_field) else $error("can rx field not from bits 14..12"); // RULE7

  property p_ext4_field;
    @(posedge clk_i) disable iff (!reset_n_i)
    wr_c |=> level_q[SRC_EXT4] == $past(pwdata_i[10:8]);
  endproperty
  a_ext4_field: assert property (p_ext4_field) else $error("ext four field not from bits 10..8"); // RULE8

  property p_ext3_field;
    @(posedge clk_i) disable iff (!reset_n_i)
    wr_c |=> level_q[SRC_EXT3] == $past(pwdata_i[6:4]);
  endproperty
  a_ext3_field: assert property (p_ext3_field) else $error("ext three field not from bits 6..4"); // RULE9

  property p_t9_field;
    @(posedge clk_i) disable iff (!reset_n_i)
    wr_c |=> level_q[SRC_TIMER9] == $past(pwdata_i[2:0]);
  endproperty
  a_t9_field: assert property (p_t9_field) else $error("timer nine field not from bits 2..0"); // RULE10

  property p_t7_field;
    @(posedge clk_i) disable iff (!reset_n_i)
    (!wr_b ##1 wr_b) |=> level_q[SRC_TIMER7] == $past(pwdata_i[2:0]) && $stable(level_q[SRC_CAN2_RX]);
  endproperty
  a_t7_field: assert property (p_t7_field) else $error("timer seven field wrong or group_c disturbed"); // RULE11

  // Bus answer checks; software polling relies on exactly one access cycle
  property p_ready_pulse;
    @(posedge clk_i) disable iff (!reset_n_i)
    pready_q |=> !pready_q;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready stood longer than one cycle");

  property p_ready_after_setup;
    @(posedge clk_i) disable iff (!reset_n_i)
    setup |=> pready_q;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");

  property p_ready_cause;
    @(posedge clk_i) disable iff (!reset_n_i)
    pready_q |-> $past(setup);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready without a setup cycle");

  property p_err_with_ready;
    @(posedge clk_i) disable iff (!reset_n_i)
    pslverr_q |-> pready_q;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error flag outside access cycle");

  property p_err_unmapped;
    @(posedge clk_i) disable iff (!reset_n_i)
    (setup && !(hit_b || hit_c)) |=> pslverr_q;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not flagged");

  property p_idle_data_zero;
    @(posedge clk_i) disable iff (!reset_n_i)
    !pready_q |-> prdata_q == 32'h0000_0000;
  endproperty
  a_idle_data_zero: assert property (p_idle_data_zero) else $error("read data not zero while idle");

  // Read-back of whole words; fields must come back as written
  property p_read_word_b;
    @(posedge clk_i) disable iff (!reset_n_i)
    (setup && !pwrite_i && hit_b) |=> prdata_q[15:0] == {9'h000, level_q[SRC_I2C_SLAVE2], 1'b0, level_q[SRC_TIMER7]};
  endproperty
  a_read_word_b: assert property (p_read_word_b) else $error("group_b read word wrong"); // RULE4

  property p_read_word_c;
    @(posedge clk_i) disable iff (!reset_n_i)
    (setup && !pwrite_i && hit_c) |=> prdata_q[15:0] == {1'b0, level_q[SRC_CAN2_RX], 1'b0, level_q[SRC_EXT4],
      1'b0, level_q[SRC_EXT3], 1'b0, level_q[SRC_TIMER9]};
  endproperty
  a_read_word_c: assert property (p_read_word_c) else $error("group_c read word wrong"); // RULE4

  // Writes must not leak into the other register or from unmapped places
  property p_unmapped_write;
    @(posedge clk_i) disable iff (!reset_n_i)
    (commit && pwrite_i && !(hit_b || hit_c)) |=> $stable(en_q) && $stable(level_q[SRC_TIMER9]);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write changed a field");

  property p_b_keeps_c;
    @(posedge clk_i) disable iff (!reset_n_i)
    wr_b |=> $stable(level_q[SRC_EXT4]) && $stable(level_q[SRC_EXT3]) && $stable(level_q[SRC_TIMER9]);
  endproperty
  a_b_keeps_c: assert property (p_b_keeps_c) else $error("group_b write disturbed group_c"); // RULE6

  property p_c_keeps_b;
    @(posedge clk_i) disable iff (!reset_n_i)
    wr_c |=> $stable(level_q[SRC_I2C_SLAVE2]) && $stable(level_q[SRC_TIMER7]);
  endproperty
  a_c_keeps_b: assert property (p_c_keeps_b) else $error("group_c write disturbed group_b"); // RULE7

  property p_hold_no_write;
    @(posedge clk_i) disable iff (!reset_n_i)
    (!wr_b && !wr_c) |=> $stable(en_q) && $stable(level_q[SRC_CAN2_RX]);
  endproperty
  a_hold_no_write: assert property (p_hold_no_write) else $error("field changed without a write"); // RULE4

  // Enable must follow the code in every cycle
  property p_enable_t9;
    @(posedge clk_i) disable iff (!reset_n_i)
    en_q[SRC_TIMER9] == (level_q[SRC_TIMER9] != PRIO_OFF);
  endproperty
  a_enable_t9: assert property (p_enable_t9) else $error("timer nine enable disagrees with code"); // RULE2

  property p_enable_i2c;
    @(posedge clk_i) disable iff (!reset_n_i)
    en_q[SRC_I2C_SLAVE2] == (level_q[SRC_I2C_SLAVE2] != PRIO_OFF);
  endproperty
  a_enable_i2c: assert property (p_enable_i2c) else $error("i2c slave enable disagrees with code"); // RULE2

  property p_i2c_max;
    @(posedge clk_i) disable iff (!reset_n_i)
    (wr_b && pwdata_i[6:4] == PRIO_MAX) |=> level_q[SRC_I2C_SLAVE2] == 3'h7 && en_q[SRC_I2C_SLAVE2];
  endproperty
  a_i2c_max: assert property (p_i2c_max) else $error("i2c slave all-ones code not level seven"); // RULE1

endmodule

// ---- testbench/ipf_tb.sv ----
`timescale 1ns/1ps
module testbench
  import ipf_pkg::*;
;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  ipf_src_s [NSRC-1:0] src;
  logic [15:0] bq;
  logic [15:0] cq;
  logic [15:0] lf = 16'hB994;
  logic [11:0] ads [4] = '{OFS_GROUP_B, OFS_GROUP_C, 12'h008, 12'hFFC};
  int bad_count = 0;
  int num_checks = 0;

  ipf_top dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .src_o(src));

  // Bus clock, 25 ns period
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic conclude;
    if (bad_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Model fields against every arbiter-facing output
  task automatic chk_src;
    logic [15:0] w;
    logic [2:0] l;
    @(negedge clk_i);
    chk("pready_idle", {31'h0, pready}, 32'h0);
    chk("prdata_idle", prdata, 32'h0);
    for (int i = 0; i < NSRC; i++)
    begin
      w = SRC_REG[i] ? cq : bq;
      l = w[SRC_LSB[i] +: 3];
      chk("src", {28'h0, src[i]}, {28'h0, l, |l});
    end
  endtask

  // Reset pulse; model returns to level four everywhere
  task automatic do_reset;
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    bq = 16'h0044;
    cq = 16'h4444;
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    chk_src;
  endtask

  // One APB transfer; waits on pready, bounded so a hang cannot stall
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    logic ok;
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    chk("pready", {31'h0, pready}, 32'h1);
    rd = prdata;
    er = pslverr;
    @(posedge clk_i);
    psel <= 1'b0;
    pen <= 1'b0;
    ok = (a == OFS_GROUP_B) || (a == OFS_GROUP_C);
    chk("pslverr", {31'h0, er}, {31'h0, !ok});
    chk("prdata", rd, (w || !ok) ? 32'h0 : {16'h0, (a == OFS_GROUP_B) ? bq : cq});
    if (w && a == OFS_GROUP_B)
      bq = d[15:0] & 16'h0077;
    if (w && a == OFS_GROUP_C)
      cq = d[15:0] & 16'h7777;
    chk_src;
  endtask

  // Main sequence
  initial
  begin
    do_reset;
    xfer(1'b0, OFS_GROUP_B, 32'h0);
    xfer(1'b0, OFS_GROUP_C, 32'h0);
    xfer(1'b0, 12'h008, 32'h0);
    // Every code in every field, reserved bits written high
    for (int c = 0; c < 8; c++)
    begin
      xfer(1'b1, OFS_GROUP_B, {8{1'b1, 3'(c)}});
      xfer(1'b1, OFS_GROUP_C, {8{1'b1, 3'(7 - c)}});
      xfer(1'b0, OFS_GROUP_B, 32'h0);
      xfer(1'b0, OFS_GROUP_C, 32'h0);
    end
    // Random traffic, unmapped places included
    repeat (60)
    begin
      lf = nxt(lf);
      xfer(lf[0], ads[lf[2:1]], {lf, nxt(lf)});
    end
    // Reset in mid-run restores defaults
    do_reset;
    xfer(1'b0, OFS_GROUP_B, 32'h0);
    xfer(1'b0, OFS_GROUP_C, 32'h0);
    conclude;
  end

  // Watchdog well beyond the expected run
  initial
  begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    conclude;
  end
endmodule
